//--- src/pin_ctl_pkg.sv
package pin_ctl_pkg;

  // Register byte offsets on the APB window
  localparam logic [7:0] OFF_DATA      = 8'h00;
  localparam logic [7:0] OFF_INPUT     = 8'h04;
  localparam logic [7:0] OFF_DIR       = 8'h08;
  localparam logic [7:0] OFF_REDUCED   = 8'h0C;
  localparam logic [7:0] OFF_PULL_EN   = 8'h10;
  localparam logic [7:0] OFF_PULL_POL  = 8'h14;
  localparam logic [7:0] OFF_ROUTE_HI  = 8'h18;
  localparam logic [7:0] OFF_ROUTE_LO  = 8'h1C;
  localparam logic [7:0] OFF_EFF_DIR   = 8'h20;

  // Values after reset
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [7:0] RST_DIR       = 8'h00;
  localparam logic [7:0] RST_REDUCED   = 8'h00;
  localparam logic [7:0] RST_PULL_EN   = 8'hFF;
  localparam logic [7:0] RST_PULL_POL  = 8'h00;
  localparam logic [1:0] RST_ROUTE_HI  = 2'h0;
  localparam logic [7:0] RST_ROUTE_LO  = 8'h00;
  localparam logic [2:0] RST_SYNC      = 3'h0;

  // Routing codes for channels 7 and 6
  localparam logic [1:0] ROUTE_PORT_S  = 2'h1;
  localparam logic [1:0] ROUTE_PORT_V  = 2'h2;

  // Field positions in the low routing register
  localparam int ROUTE_CH6_LSB = 6;
  localparam int ROUTE_CH5_BIT = 5;
  localparam int ROUTE_CH4_BIT = 4;

  // Line index of the channel that has the shutdown input
  localparam int LINE_SHUTDOWN = 7;

  // Pad controls of one 8-line port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] in_en;
    logic [7:0] reduced;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
  } pad_ctl_t;

  // PWM channel outputs placed on an alternative port
  typedef struct packed {
    logic [7:0] s_en;
    logic [7:0] s_out;
    logic [3:0] v_en;
    logic [3:0] v_out;
  } pwm_route_t;

endpackage

//--- src/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // Three-stage chain; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit changes once the last two stages agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          sync_o[i] <= stage3_reg[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- src/port_p_pin_control_routing.sv
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module port_p_pin_control_routing (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // APB slave
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [7:0]              paddr_i,
  input  wire logic [31:0]             pwdata_i,
  input  wire logic [3:0]              pstrb_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // Port P pads
  input  wire logic [7:0]              pad_in_i,
  output pin_ctl_pkg::pad_ctl_t        pad_ctl_o,
  // PWM and LCD segment driver
  input  wire logic [7:0]              pwm_en_i,
  input  wire logic [7:0]              pwm_out_i,
  input  wire logic                    pwm_shutdown_en_i,
  input  wire logic [7:0]              lcd_seg_en_i,
  // Alternative port placement of PWM outputs
  output pin_ctl_pkg::pwm_route_t      pwm_route_o,
  // Edge polarity for the port interrupt logic
  output logic      [7:0]              irq_rising_edge_o
);

  // Control registers
  logic [7:0] port_p_data_reg;
  logic [7:0] port_p_direction_reg;
  logic [7:0] port_p_reduced_drive_reg;
  logic [7:0] port_p_pull_enable_reg;
  logic [7:0] port_p_pull_polarity_reg;
  logic [1:0] pwm_route_high_reg;
  logic [7:0] pwm_route_low_reg;

  // Derived pin state
  logic [7:0] pin_level;
  logic [7:0] pwm_on_p;
  logic [7:0] force_out;
  logic [7:0] force_in;
  logic [7:0] is_output;
  logic [7:0] pin_out_next;
  logic [7:0] eff_dir_reg;

  // Bus decode
  logic       wr_access;
  logic       rd_access;
  logic       addr_hit;
  logic [7:0] rd_next;

  // Channel mask kept on port P for a routing setting
  function automatic logic [7:0] route_to_p(input logic [1:0] hi,
                                            input logic [7:0] lo);
    logic [1:0] ch6;
    ch6 = lo[pin_ctl_pkg::ROUTE_CH6_LSB +: 2];
    route_to_p[7]   = !(hi == pin_ctl_pkg::ROUTE_PORT_S ||
                        hi == pin_ctl_pkg::ROUTE_PORT_V);
    route_to_p[6]   = !(ch6 == pin_ctl_pkg::ROUTE_PORT_S ||
                        ch6 == pin_ctl_pkg::ROUTE_PORT_V);
    route_to_p[5:0] = ~lo[5:0];
  endfunction

  // Byte-lane merge for a write
  function automatic logic [7:0] lane0(input logic [7:0]  old_val,
                                       input logic [31:0] wdata,
                                       input logic [3:0]  strb);
    lane0 = strb[0] ? wdata[7:0] : old_val;
  endfunction

  // Filter the pad levels into the clock domain
  pin_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (pad_in_i),
    .sync_o  (pin_level)
  );

  // APB handshake; every access completes in its first access cycle
  assign pready_o  = 1'b1;
  assign wr_access = psel_i && penable_i && pwrite_i && !pslverr_o;
  assign rd_access = psel_i && !penable_i && !pwrite_i;

  // Address decode; unmapped offsets answer with an error
  always_comb begin
    addr_hit = 1'b1;
    if (paddr_i == pin_ctl_pkg::OFF_DATA) begin
      rd_next = 8'h00;
      for (int i = 0; i < 8; i++) begin
        rd_next[i] = port_p_direction_reg[i] ? port_p_data_reg[i]
                                             : pin_level[i];
      end
    end else if (paddr_i == pin_ctl_pkg::OFF_INPUT) begin
      rd_next = pin_level;
    end else if (paddr_i == pin_ctl_pkg::OFF_DIR) begin
      rd_next = port_p_direction_reg;
    end else if (paddr_i == pin_ctl_pkg::OFF_REDUCED) begin
      rd_next = port_p_reduced_drive_reg;
    end else if (paddr_i == pin_ctl_pkg::OFF_PULL_EN) begin
      rd_next = port_p_pull_enable_reg;
    end else if (paddr_i == pin_ctl_pkg::OFF_PULL_POL) begin
      rd_next = port_p_pull_polarity_reg;
    end else if (paddr_i == pin_ctl_pkg::OFF_ROUTE_HI) begin
      rd_next = {6'h00, pwm_route_high_reg};
    end else if (paddr_i == pin_ctl_pkg::OFF_ROUTE_LO) begin
      rd_next = pwm_route_low_reg;
    end else if (paddr_i == pin_ctl_pkg::OFF_EFF_DIR) begin
      rd_next = eff_dir_reg;
    end else begin
      rd_next  = 8'h00;
      addr_hit = 1'b0;
    end
  end

  // Error flag is a pure function of the held address and the access phase
  assign pslverr_o = psel_i && penable_i && !addr_hit;

  // Read data captured in the setup cycle, held through access
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_access) begin
      prdata_o <= {24'h00_0000, rd_next};
    end
  end

  // Output latch of the port
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      port_p_data_reg <= pin_ctl_pkg::RST_DATA;
    end else if (wr_access && paddr_i == pin_ctl_pkg::OFF_DATA) begin
      port_p_data_reg <= lane0(port_p_data_reg, pwdata_i, pstrb_i);
    end
  end

  // Direction bits change only by software writes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      port_p_direction_reg <= pin_ctl_pkg::RST_DIR;
    end else if (wr_access && paddr_i == pin_ctl_pkg::OFF_DIR) begin
      port_p_direction_reg <= lane0(port_p_direction_reg, pwdata_i,
                                    pstrb_i);
    end
  end

  // Drive strength selection
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      port_p_reduced_drive_reg <= pin_ctl_pkg::RST_REDUCED;
    end else if (wr_access && paddr_i == pin_ctl_pkg::OFF_REDUCED) begin
      port_p_reduced_drive_reg <= lane0(port_p_reduced_drive_reg,
                                        pwdata_i, pstrb_i);
    end
  end

  // Pull device enables, all on out of reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      port_p_pull_enable_reg <= pin_ctl_pkg::RST_PULL_EN;
    end else if (wr_access && paddr_i == pin_ctl_pkg::OFF_PULL_EN) begin
      port_p_pull_enable_reg <= lane0(port_p_pull_enable_reg,
                                      pwdata_i, pstrb_i);
    end
  end

  // Pull polarity and interrupt edge select
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      port_p_pull_polarity_reg <= pin_ctl_pkg::RST_PULL_POL;
    end else if (wr_access && paddr_i == pin_ctl_pkg::OFF_PULL_POL) begin
      port_p_pull_polarity_reg <= lane0(port_p_pull_polarity_reg,
                                        pwdata_i, pstrb_i);
    end
  end

  // Routing of channel 7; only two bits exist
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwm_route_high_reg <= pin_ctl_pkg::RST_ROUTE_HI;
    end else if (wr_access && paddr_i == pin_ctl_pkg::OFF_ROUTE_HI
                 && pstrb_i[0]) begin
      pwm_route_high_reg <= pwdata_i[1:0];
    end
  end

  // Routing of channels 6 to 0
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwm_route_low_reg <= pin_ctl_pkg::RST_ROUTE_LO;
    end else if (wr_access && paddr_i == pin_ctl_pkg::OFF_ROUTE_LO) begin
      pwm_route_low_reg <= lane0(pwm_route_low_reg, pwdata_i,
                                 pstrb_i);
    end
  end

  // Channels that are enabled and still placed on port P
  assign pwm_on_p = pwm_en_i &
                    route_to_p(pwm_route_high_reg, pwm_route_low_reg);

  // Override priority per line: LCD, shutdown, PWM, direction bit
  always_comb begin
    force_in  = 8'h00;
    force_out = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (lcd_seg_en_i[i]) begin
        force_in[i]  = 1'b0;
        force_out[i] = 1'b0;
      end else if (i == pin_ctl_pkg::LINE_SHUTDOWN && pwm_shutdown_en_i) begin
        force_in[i]  = 1'b1;
      end else if (pwm_on_p[i]) begin
        force_out[i] = 1'b1;
      end
    end
  end

  // Effective direction; stored bits used when nothing overrides
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (lcd_seg_en_i[i] || force_in[i]) begin
        is_output[i] = 1'b0;
      end else if (force_out[i]) begin
        is_output[i] = 1'b1;
      end else begin
        is_output[i] = port_p_direction_reg[i];
      end
    end
  end

  // Value driven by each line
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_out_next[i] = pwm_on_p[i] ? pwm_out_i[i] : port_p_data_reg[i];
    end
  end

  // Effective direction as seen by software
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      eff_dir_reg <= pin_ctl_pkg::RST_DIR;
    end else begin
      eff_dir_reg <= is_output;
    end
  end

  // Pad controls registered; low output enable drives the pad
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pad_ctl_o.out       <= 8'h00;
      pad_ctl_o.oe_n      <= 8'hFF;
      pad_ctl_o.in_en     <= 8'hFF;
      pad_ctl_o.reduced   <= 8'h00;
      pad_ctl_o.pull_en   <= pin_ctl_pkg::RST_PULL_EN;
      pad_ctl_o.pull_down <= pin_ctl_pkg::RST_PULL_POL;
    end else begin
      pad_ctl_o.out     <= pin_out_next;
      pad_ctl_o.oe_n    <= ~is_output;
      pad_ctl_o.in_en   <= ~lcd_seg_en_i;
      pad_ctl_o.reduced <= port_p_reduced_drive_reg & is_output;
      pad_ctl_o.pull_en <= port_p_pull_enable_reg & ~is_output &
                           ~lcd_seg_en_i;
      pad_ctl_o.pull_down <= port_p_pull_polarity_reg &
                             port_p_pull_enable_reg &
                             ~is_output & ~lcd_seg_en_i;
    end
  end

  // Edge polarity follows the pull polarity bits
  assign irq_rising_edge_o = port_p_pull_polarity_reg;

  // Placement of channels on ports S and V
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwm_route_o <= '0;
    end else begin
      pwm_route_o.s_en[1] <= pwm_en_i[7] &&
        pwm_route_high_reg == pin_ctl_pkg::ROUTE_PORT_S;
      pwm_route_o.v_en[3] <= pwm_en_i[7] &&
        pwm_route_high_reg == pin_ctl_pkg::ROUTE_PORT_V;
      pwm_route_o.s_en[0] <= pwm_en_i[6] &&
        pwm_route_low_reg[pin_ctl_pkg::ROUTE_CH6_LSB +: 2] ==
        pin_ctl_pkg::ROUTE_PORT_S;
      pwm_route_o.v_en[2] <= pwm_en_i[6] &&
        pwm_route_low_reg[pin_ctl_pkg::ROUTE_CH6_LSB +: 2] ==
        pin_ctl_pkg::ROUTE_PORT_V;
      pwm_route_o.v_en[1] <= pwm_en_i[5] &&
        pwm_route_low_reg[pin_ctl_pkg::ROUTE_CH5_BIT];
      pwm_route_o.v_en[0] <= pwm_en_i[4] &&
        pwm_route_low_reg[pin_ctl_pkg::ROUTE_CH4_BIT];
      pwm_route_o.s_en[7:4] <= pwm_en_i[3:0] &
                               pwm_route_low_reg[3:0];
      pwm_route_o.s_en[3:2] <= 2'h0;
      pwm_route_o.s_out <= {pwm_out_i[3:0], 2'h0,
                            pwm_out_i[7], pwm_out_i[6]};
      pwm_route_o.v_out <= {pwm_out_i[7], pwm_out_i[6],
                            pwm_out_i[5], pwm_out_i[4]};
    end
  end

endmodule

`default_nettype wire

//--- tb/pin_ctl_properties.sv
`timescale 1ns/1ns
`default_nettype none

module pin_ctl_properties (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pready_o,
  input  wire logic                   pslverr_o,
  // Pads and sources
  input  wire pin_ctl_pkg::pad_ctl_t  pad_ctl_o,
  input  wire logic [7:0]             pwm_en_i,
  input  wire logic [7:0]             pwm_out_i,
  input  wire logic                   pwm_shutdown_en_i,
  input  wire logic [7:0]             lcd_seg_en_i,
  input  wire pin_ctl_pkg::pwm_route_t pwm_route_o,
  input  wire logic [7:0]             irq_rising_edge_o
);
  logic [7:0] lcd_reg;
  logic [7:0] pwm_en_reg;
  logic [7:0] pwm_out_reg;
  logic [7:0] pol_reg;
  logic       shut_reg;
  logic       rst_reg;
  logic [7:0] away;
  logic [7:0] forced;

  // Inputs as seen by the pad flops one edge earlier
  always_ff @(posedge clk_i) begin
    lcd_reg     <= lcd_seg_en_i;
    pwm_en_reg  <= pwm_en_i;
    pwm_out_reg <= pwm_out_i;
    pol_reg     <= irq_rising_edge_o;
    shut_reg    <= pwm_shutdown_en_i;
    rst_reg     <= reset_i;
  end

  // Lines whose channel is placed on port S or V, and lines PWM owns
  assign away = {pwm_route_o.s_en[1] | pwm_route_o.v_en[3],
                 pwm_route_o.s_en[0] | pwm_route_o.v_en[2],
                 pwm_route_o.v_en[1:0], pwm_route_o.s_en[7:4]};
  assign forced = pwm_en_reg & ~lcd_reg & ~away & ~{shut_reg, 7'h00};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence setup_s;
    psel_i && !penable_i;
  endsequence

  lcd_owns_a: assert property (!rst_reg |-> (pad_ctl_o.oe_n & lcd_reg) == lcd_reg
    && (pad_ctl_o.in_en & lcd_reg) == 8'h00 && (pad_ctl_o.pull_en & lcd_reg) == 8'h00)
    else $error("lcd line not released");
  pwm_forces_a: assert property (!rst_reg |-> (pad_ctl_o.oe_n & forced) == 8'h00
    && ((pad_ctl_o.out ^ pwm_out_reg) & forced) == 8'h00)
    else $error("pwm line not driven");
  shutdown_input_a: assert property (shut_reg && !lcd_reg[7] && !rst_reg |->
    pad_ctl_o.oe_n[7]) else $error("shutdown line driven");
  reduced_output_a: assert property ((pad_ctl_o.reduced & pad_ctl_o.oe_n) == 8'h00)
    else $error("reduced drive on input");
  pull_input_a: assert property ((pad_ctl_o.pull_en & ~pad_ctl_o.oe_n) == 8'h00)
    else $error("pull on output");
  reset_pulls_a: assert property ($past(reset_i) |-> pad_ctl_o.pull_en == 8'hFF
    && pad_ctl_o.oe_n == 8'hFF) else $error("reset pad state");
  polarity_pull_a: assert property (!rst_reg |->
    (pad_ctl_o.pull_en & (pad_ctl_o.pull_down ^ pol_reg)) == 8'h00)
    else $error("pull polarity");
  route_levels_a: assert property (!rst_reg |-> pwm_route_o.v_out == pwm_out_reg[7:4]
    && pwm_route_o.s_out[7:4] == pwm_out_reg[3:0] && pwm_route_o.s_en[3:2] == 2'h0)
    else $error("routed levels");
  route_exclusive_a: assert property (!(pwm_route_o.s_en[1] && pwm_route_o.v_en[3])
    && !(pwm_route_o.s_en[0] && pwm_route_o.v_en[2])) else $error("double route");
  apb_ready_a: assert property (setup_s ##1 (psel_i && penable_i) |-> pready_o)
    else $error("access not completed");
  apb_err_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access");
endmodule

bind port_p_pin_control_routing pin_ctl_properties u_props (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pad_ctl_o(pad_ctl_o),
  .pwm_en_i(pwm_en_i), .pwm_out_i(pwm_out_i),
  .pwm_shutdown_en_i(pwm_shutdown_en_i), .lcd_seg_en_i(lcd_seg_en_i),
  .pwm_route_o(pwm_route_o), .irq_rising_edge_o(irq_rising_edge_o));

`default_nettype wire

//--- tb/pin_world.sv
`timescale 1ns/1ns
`default_nettype none

module pin_world (
  // Clock
  input  wire logic                  clk_i,
  // Pad controls and resulting levels
  input  wire pin_ctl_pkg::pad_ctl_t pad_ctl_i,
  output logic [7:0]                 pad_o
);
  logic [7:0] drift;

  // Floating pads wander every cycle
  always @(posedge clk_i) begin
    drift <= ~drift;
  end

  initial drift = 8'h5A;

  // Driver first, then pull device, else floating
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (!pad_ctl_i.oe_n[k]) begin
        pad_o[k] = pad_ctl_i.out[k];
      end else if (pad_ctl_i.pull_en[k]) begin
        pad_o[k] = ~pad_ctl_i.pull_down[k];
      end else begin
        pad_o[k] = drift[k];
      end
    end
  end
endmodule

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [7:0] pad_in_i;
  pin_ctl_pkg::pad_ctl_t pad_ctl_o;
  logic [7:0] pwm_en_i = 8'h00;
  logic [7:0] pwm_out_i = 8'h00;
  logic pwm_shutdown_en_i = 1'b0;
  logic [7:0] lcd_seg_en_i = 8'h00;
  pin_ctl_pkg::pwm_route_t pwm_route_o;
  logic [7:0] irq_rising_edge_o;
  int mismatches = 0;
  int checked = 0;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  port_p_pin_control_routing u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pad_in_i(pad_in_i), .pad_ctl_o(pad_ctl_o),
    .pwm_en_i(pwm_en_i), .pwm_out_i(pwm_out_i),
    .pwm_shutdown_en_i(pwm_shutdown_en_i), .lcd_seg_en_i(lcd_seg_en_i),
    .pwm_route_o(pwm_route_o), .irq_rising_edge_o(irq_rising_edge_o));

  pin_world u_pins (.clk_i(clk_i), .pad_ctl_i(pad_ctl_o), .pad_o(pad_in_i));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk32({24'h0, got}, {24'h0, exp});
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'hC3C3C3, d};
    pstrb_i <= 4'hF;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk32(r, {24'h0, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Reset values, read-back and the unmapped place
  task automatic t_registers;
    logic [7:0] regs [5];
    logic [31:0] r;
    logic e;
    regs = '{pin_ctl_pkg::OFF_DIR, pin_ctl_pkg::OFF_REDUCED,
             pin_ctl_pkg::OFF_PULL_EN, pin_ctl_pkg::OFF_PULL_POL,
             pin_ctl_pkg::OFF_ROUTE_LO};
    chk8(pad_ctl_o.pull_en, 8'hFF);
    rd_check(pin_ctl_pkg::OFF_PULL_EN, 8'hFF);
    rd_check(pin_ctl_pkg::OFF_DIR, pin_ctl_pkg::RST_DIR);
    for (int i = 0; i < 5; i++) begin
      wr(regs[i], 8'h5A);
      rd_check(regs[i], 8'h5A);
    end
    wr(pin_ctl_pkg::OFF_ROUTE_HI, 8'hFF);
    rd_check(pin_ctl_pkg::OFF_ROUTE_HI, 8'h03);
    apb(1'b1, 8'h40, 8'hFF, r, e);
    apb(1'b0, 8'h40, 8'h00, r, e);
    chk32(r, 32'h0);
    chk8({7'h0, e}, 8'h01);
  endtask

  // Direction, drive, pulls and data read-back
  task automatic t_direction;
    wr(pin_ctl_pkg::OFF_ROUTE_HI, 8'h00);
    wr(pin_ctl_pkg::OFF_ROUTE_LO, 8'h00);
    wr(pin_ctl_pkg::OFF_DIR, 8'hF0);
    wr(pin_ctl_pkg::OFF_REDUCED, 8'hFF);
    wr(pin_ctl_pkg::OFF_PULL_EN, 8'hFF);
    wr(pin_ctl_pkg::OFF_PULL_POL, 8'h0F);
    wr(pin_ctl_pkg::OFF_DATA, 8'hA5);
    settle(2);
    chk8(pad_ctl_o.oe_n, 8'h0F);
    chk8(pad_ctl_o.out & 8'hF0, 8'hA0);
    chk8(pad_ctl_o.reduced, 8'hF0);
    chk8(pad_ctl_o.pull_en, 8'h0F);
    chk8(pad_ctl_o.pull_down & 8'h0F, 8'h0F);
    chk8(irq_rising_edge_o, 8'h0F);
    settle(8);
    rd_check(pin_ctl_pkg::OFF_DATA, 8'hA0);
    rd_check(pin_ctl_pkg::OFF_INPUT, 8'hA0);
  endtask

  // LCD, shutdown and PWM overrides, routing codes
  task automatic t_overrides;
    logic [1:0] p;
    wr(pin_ctl_pkg::OFF_DIR, 8'h00);
    @(posedge clk_i);
    pwm_en_i <= 8'hFF;
    pwm_out_i <= 8'h3C;
    settle(2);
    chk8(pad_ctl_o.oe_n, 8'h00);
    chk8(pad_ctl_o.out, 8'h3C);
    @(posedge clk_i);
    lcd_seg_en_i <= 8'h81;
    settle(2);
    chk8(pad_ctl_o.oe_n, 8'h81);
    chk8(pad_ctl_o.in_en, 8'h7E);
    @(posedge clk_i);
    lcd_seg_en_i <= 8'h00;
    pwm_shutdown_en_i <= 1'b1;
    settle(2);
    chk8(pad_ctl_o.oe_n, 8'h80);
    rd_check(pin_ctl_pkg::OFF_DIR, 8'h00);
    @(posedge clk_i);
    pwm_shutdown_en_i <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(pin_ctl_pkg::OFF_ROUTE_HI, c[7:0]);
      wr(pin_ctl_pkg::OFF_ROUTE_LO, {c[1:0], 6'h00});
      settle(2);
      p = (c == 1 || c == 2) ? 2'h3 : 2'h0;
      chk8({6'h0, pad_ctl_o.oe_n[7:6]}, {6'h0, p});
      chk8({6'h0, pwm_route_o.s_en[1:0]}, (c == 1) ? 8'h03 : 8'h00);
      chk8({6'h0, pwm_route_o.v_en[3:2]}, (c == 2) ? 8'h03 : 8'h00);
    end
    wr(pin_ctl_pkg::OFF_ROUTE_HI, 8'h01);
    wr(pin_ctl_pkg::OFF_ROUTE_LO, 8'h3F);
    settle(2);
    chk8(pad_ctl_o.oe_n, 8'hBF);
    chk8(pwm_route_o.s_en, 8'hF2);
    chk8({4'h0, pwm_route_o.v_en}, 8'h03);
    rd_check(pin_ctl_pkg::OFF_EFF_DIR, 8'h40);
  endtask

  task automatic conclude;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    settle(1);
    t_registers();
    t_direction();
    t_overrides();
    conclude();
  end

  // Watchdog well beyond the expected run of about 155 cycles
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule

`default_nettype wire
